/* include/ir_modes_pkg.sv */
// constants and enumerations of the ask / tv infrared codec
// assumes one 125 MHz clock and a sync active high reset
package ir_modes_pkg;
    // clock rate and the fixed ask carrier
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int ASK_CARRIER_KHZ = 500;
    localparam logic [7:0] ASK_CAR_PERIOD = 8'(CLK_FREQ_KHZ / ASK_CARRIER_KHZ);
    localparam logic [7:0] ASK_CAR_HIGH = 8'(CLK_FREQ_KHZ / (2 * ASK_CARRIER_KHZ));
    // prescaler default, used while the port is zero
    localparam logic [7:0] CLOCK_PRESCALER_DEFAULT = 8'h1A;
    // mode field and eot method bit of the mode definition register
    localparam logic [2:0] MODE_ASK = 3'h2;
    localparam logic [2:0] MODE_TV = 3'h3;
    localparam int MDR_EOT_METHOD = 7;
    // single control bits
    localparam int ACR_TX_EN = 7;
    localparam int ACR_RX_EN = 6;
    localparam int ACR_EOT = 0;
    localparam int LCR_UNLOCK = 7;
    localparam int FCR_CLEAR = 5;
    localparam int MCR_IRQ_EN = 3;
    localparam int INFRARED_CONFIG_RX_SEL = 1;
    // remote mode configuration fields
    localparam int REMOTE_MODE_CONFIG_RX_ACTIVE = 7;
    localparam int REMOTE_MODE_CONFIG_DEMOD_EN = 6;
    localparam int REMOTE_MODE_CONFIG_PLS_HI = 5;
    localparam int REMOTE_MODE_CONFIG_PLS_LO = 4;
    localparam int REMOTE_MODE_CONFIG_RLE = 3;
    localparam int REMOTE_MODE_CONFIG_OVERSAMPLE = 2;
    localparam int REMOTE_MODE_CONFIG_TX_RANGE = 1;
    localparam int REMOTE_MODE_CONFIG_RX_RANGE = 0;
    // interrupt identification and enable bits
    localparam int IIR_RX_THR = 0;
    localparam int IIR_TX_THR = 1;
    localparam int IIR_RX_OVR = 4;
    localparam int IIR_TX_UNR = 5;
    localparam int IER_RX_THR = 0;
    localparam int IER_TX_THR = 1;
    localparam int IER_RX_OVR = 3;
    localparam int IER_TX_UNR = 5;
    // sixteen samples per bit, eight data bits
    localparam logic [3:0] SAMPLE_MID = 4'h8;
    localparam logic [3:0] SAMPLE_LAST = 4'hF;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [3:0] SIX_PULSES = 4'h6;
    localparam logic [3:0] EIGHT_PULSES = 4'h8;
    // fifo word: data byte plus eot tag
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [1:0] {
        continuous_pulse_mod = 2'b00,
        six_pulse_mod = 2'b01,
        eight_pulse_mod = 2'b10
    } pulse_mod_e;
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_START = 2'b01,
        CH_DATA = 2'b10,
        CH_STOP = 2'b11
    } char_state_e;
endpackage

/* src/ir_clk_div.sv */
// modulo counter: one tick every divisor enables
// assumes divisor is held steady; zero is treated as one
`timescale 1ns/10ps
`default_nettype none
module ir_clk_div #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // count control
    input wire logic enable,
    input wire logic [WIDTH-1:0] divisor,
    // tick out
    output logic tick_q
);
    logic [WIDTH-1:0] cnt_q; // enables seen since the last tick
    wire wrap = (divisor == '0) || (cnt_q >= divisor - WIDTH'(1));

    // count enables, tick and restart on wrap
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= enable && wrap;
            if (enable)
                cnt_q <= wrap ? '0 : cnt_q + WIDTH'(1);
        end
    end
endmodule
`default_nettype wire

/* src/ir_tx_fifo.sv */
// first word fall through fifo, registered output word and full flag
// assumes one clock; clear empties it in one cycle
`timescale 1ns/10ps
`default_nettype none
module ir_tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clear,
    // fill side
    input wire logic [WIDTH-1:0] s_data,
    input wire logic s_valid,
    output logic s_ready_q,
    // drain side
    output logic [WIDTH-1:0] m_data_q,
    output logic m_valid_q,
    input wire logic m_ready,
    // array fill level, output word excluded
    output logic [$clog2(DEPTH):0] level_q
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    wire push = s_valid && s_ready_q;
    wire out_free = !m_valid_q || m_ready;
    wire pop = out_free && (level_q != '0);
    wire [AW:0] lvl_d = level_q + (AW+1)'(push) - (AW+1)'(pop);
    wire valid_d = out_free ? pop : m_valid_q; // output word held next cycle

    // storage array, no reset needed
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_q[wr_q] <= s_data;
    end

    // pointers, level, full flag and output word
    always_ff @(posedge core_clk)
    begin
        if (reset || clear)
        begin
            wr_q <= '0;
            rd_q <= '0;
            level_q <= '0;
            s_ready_q <= 1'b1;
            m_valid_q <= 1'b0;
            m_data_q <= '0;
        end
        else
        begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            level_q <= lvl_d;
            // registered so full never races the source
            s_ready_q <= ((lvl_d + (AW+1)'(valid_d)) != (AW+1)'(DEPTH));
            if (pop)
                m_data_q <= mem_q[rd_q];
            if (out_free)
                m_valid_q <= pop;
        end
    end
endmodule
`default_nettype wire

/* src/ir_ask_tv_codec.sv */
// ask / tv remote infrared codec with a transmit fifo
// assumes configuration bytes are held steady by the host while a mode runs
`timescale 1ns/10ps
`default_nettype none
module ir_ask_tv_codec
    import ir_modes_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // configuration bytes from the host
    input wire logic [7:0] clock_prescaler,
    input wire logic [7:0] aux_divisor_low,
    input wire logic [7:0] aux_divisor_high,
    input wire logic [7:0] mode_definition_reg,
    input wire logic [7:0] remote_mode_config,
    input wire logic [7:0] tx_carrier_config,
    input wire logic [7:0] rx_demod_config,
    input wire logic [7:0] infrared_config,
    input wire logic [7:0] aux_control_reg,
    input wire logic [7:0] line_control_reg,
    input wire logic [7:0] modem_control_reg,
    input wire logic [7:0] interrupt_enable_reg,
    input wire logic [7:0] preamble_level_reg,
    // fifo control write strobe with its byte
    input wire logic [7:0] fifo_control_reg,
    input wire logic fifo_control_wr,
    // transmit byte stream into the fifo
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready_q,
    // received bytes and their handshake
    output logic [7:0] rx_data_q,
    output logic rx_valid_q,
    input wire logic rx_read,
    // flag clears from the host
    input wire logic overrun_clear,
    input wire logic underrun_clear,
    // status and interrupt
    output logic [7:0] interrupt_ident_reg,
    output logic irq_q,
    output logic irq_oe_q,
    // transceiver pins
    output logic ir_tx_q,
    input wire logic ir_rx_active_low,
    input wire logic ir_rx_active_high
);
    ////////////////////////////////////////
    // mode decode
    wire [2:0] mode = mode_definition_reg[2:0];
    wire is_ask = (mode == MODE_ASK);
    wire is_tv = (mode == MODE_TV);
    // tv transmit needs the eot close method
    wire tx_go = aux_control_reg[ACR_TX_EN] && (is_ask || (is_tv && mode_definition_reg[MDR_EOT_METHOD]));
    wire rx_go = aux_control_reg[ACR_RX_EN] && (is_ask || is_tv);
    wire [1:0] pls_sel = remote_mode_config[REMOTE_MODE_CONFIG_PLS_HI:REMOTE_MODE_CONFIG_PLS_LO];
    wire demod_en = remote_mode_config[REMOTE_MODE_CONFIG_DEMOD_EN];
    wire rx_active = remote_mode_config[REMOTE_MODE_CONFIG_RX_ACTIVE];
    wire oversample = remote_mode_config[REMOTE_MODE_CONFIG_OVERSAMPLE];

    ////////////////////////////////////////
    // bit timing: prescaler tick, then sixteenth-of-bit tick
    logic pre_tick;
    logic samp_tick;
    wire [7:0] clock_prescaler_eff = (clock_prescaler == 8'h00) ? CLOCK_PRESCALER_DEFAULT : clock_prescaler;
    wire [15:0] aux_div = {aux_divisor_high, aux_divisor_low};

    // divide the core clock by the prescaler
    ir_clk_div #(.WIDTH(8)) u_clock_prescaler (
        .core_clk(core_clk),
        .reset(reset),
        .enable(1'b1),
        .divisor(clock_prescaler_eff),
        .tick_q(pre_tick)
    );

    // divide by the aux divisor; sixteen ticks per bit
    ir_clk_div #(.WIDTH(16)) u_aux (
        .core_clk(core_clk),
        .reset(reset),
        .enable(pre_tick),
        .divisor(aux_div),
        .tick_q(samp_tick)
    );

    ////////////////////////////////////////
    // transmit fifo, byte tagged with eot on write
    logic [8:0] fifo_word;
    logic fifo_valid;
    logic [5:0] fifo_level;
    logic tx_pop;
    // clear counts only while unlocked
    wire fifo_clear = fifo_control_wr && fifo_control_reg[FCR_CLEAR] && line_control_reg[LCR_UNLOCK];

    ir_tx_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .clear(fifo_clear),
        .s_data({aux_control_reg[ACR_EOT], tx_data}),
        .s_valid(tx_valid),
        .s_ready_q(tx_ready_q),
        .m_data_q(fifo_word),
        .m_valid_q(fifo_valid),
        .m_ready(tx_pop),
        .level_q(fifo_level)
    );

    ////////////////////////////////////////
    // transmit character engine
    char_state_e tx_st_q;
    logic [3:0] tx_cnt_q; // sixteenths into the current bit
    logic [2:0] tx_idx_q; // data bit index
    logic [7:0] tx_sh_q; // lsb first shift register
    logic tx_eot_q; // current byte closes the frame
    logic in_frame_q; // a frame is open
    logic unr_q; // sticky underrun
    wire tx_bit_end = samp_tick && (tx_cnt_q == SAMPLE_LAST);
    wire tx_next = fifo_valid && tx_go;
    // after the stop bit: next byte, frame end or underrun
    wire tx_stop_end = (tx_st_q == CH_STOP) && tx_bit_end;
    wire tx_load = ((tx_st_q == CH_IDLE) && samp_tick && tx_next) || (tx_stop_end && !tx_eot_q && tx_next);
    wire tx_underrun = tx_stop_end && in_frame_q && !tx_eot_q && !tx_next;
    assign tx_pop = tx_load;

    // character sequencing over sixteenth ticks
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tx_st_q <= CH_IDLE;
            tx_cnt_q <= 4'h0;
            tx_idx_q <= 3'h0;
            tx_sh_q <= 8'h00;
            tx_eot_q <= 1'b0;
        end
        else if (tx_load)
        begin
            // start bit begins on the next sixteenth
            tx_st_q <= CH_START;
            tx_cnt_q <= 4'h0;
            tx_sh_q <= fifo_word[7:0];
            tx_eot_q <= fifo_word[8];
        end
        else if (samp_tick && (tx_st_q != CH_IDLE))
        begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_bit_end)
            begin
                case (tx_st_q)
                    CH_START:
                    begin
                        tx_st_q <= CH_DATA;
                        tx_idx_q <= 3'h0;
                    end
                    CH_DATA:
                    begin
                        tx_sh_q <= {1'b1, tx_sh_q[7:1]};
                        tx_idx_q <= tx_idx_q + 3'h1;
                        if (tx_idx_q == LAST_DATA_BIT)
                            tx_st_q <= CH_STOP;
                    end
                    default:
                        tx_st_q <= CH_IDLE;
                endcase
            end
        end
    end

    // frame tracking and sticky underrun; setting beats clearing
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            in_frame_q <= 1'b0;
            unr_q <= 1'b0;
        end
        else
        begin
            if (tx_load)
                in_frame_q <= 1'b1;
            else if (tx_stop_end)
                in_frame_q <= 1'b0;
            if (tx_underrun)
                unr_q <= 1'b1;
            else if (underrun_clear)
                unr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////
    // carrier: fixed in ask, programmed in tv
    logic [7:0] car_cnt_q; // position in the carrier period
    logic [3:0] pulses_q; // carrier periods sent this bit
    wire tx_bit = (tx_st_q == CH_START) ? 1'b0 : (tx_st_q == CH_DATA) ? tx_sh_q[0] : 1'b1;
    wire zero_bit = (tx_st_q != CH_IDLE) && !tx_bit;
    wire car_step = is_ask ? 1'b1 : pre_tick;
    // tv period in prescaler ticks, range bit doubles
    wire [7:0] tv_period = {3'b000, tx_carrier_config[7:3]} << tx_carrier_config[REMOTE_MODE_CONFIG_TX_RANGE];
    wire [7:0] tv_high = {5'b00000, tx_carrier_config[2:0]} + 8'h01;
    wire [7:0] car_period = is_ask ? ASK_CAR_PERIOD : tv_period;
    wire [7:0] car_high = is_ask ? ASK_CAR_HIGH : tv_high;
    wire car_wrap = car_step && (car_cnt_q + 8'h01 >= car_period);
    wire car_restart = !zero_bit || tx_bit_end || tx_load;
    // in tv, six or eight pulse trains stop early in a zero bit; ask ignores the setting
    wire pulse_ok = is_ask || (pls_sel == continuous_pulse_mod) || ((pls_sel == six_pulse_mod) && (pulses_q < SIX_PULSES)) || ((pls_sel == eight_pulse_mod) && (pulses_q < EIGHT_PULSES));

    // carrier phase and pulse counting
    always_ff @(posedge core_clk)
    begin
        if (reset || car_restart)
        begin
            car_cnt_q <= 8'h00;
            pulses_q <= 4'h0;
        end
        else if (car_wrap)
        begin
            car_cnt_q <= 8'h00;
            if (pulses_q != EIGHT_PULSES)
                pulses_q <= pulses_q + 4'h1;
        end
        else if (car_step)
            car_cnt_q <= car_cnt_q + 8'h01;
    end

    // emitter: carrier only during zero bits, dark for ones
    always_ff @(posedge core_clk)
    begin
        if (reset)
            ir_tx_q <= 1'b0;
        else
            ir_tx_q <= zero_bit && pulse_ok && (car_cnt_q < car_high);
    end

    ////////////////////////////////////////
    // receive input select and carrier detection
    wire rx_light = infrared_config[INFRARED_CONFIG_RX_SEL] ? !ir_rx_active_low : ir_rx_active_high;
    logic rx_light_q;
    logic rx_prev_q;
    logic [9:0] gap_q; // cycles since last rise, saturating
    logic car_ok_q; // in-range carrier seen
    wire rx_rise = rx_light_q && !rx_prev_q;
    // accepted period window, range bit doubles
    wire [9:0] per_lo = {3'b000, rx_demod_config[3:0], 3'b000} << remote_mode_config[REMOTE_MODE_CONFIG_RX_RANGE];
    wire [9:0] per_hi = {2'b00, rx_demod_config[7:4], 4'b0000} << remote_mode_config[REMOTE_MODE_CONFIG_RX_RANGE];
    wire in_range = (gap_q >= per_lo) && (gap_q <= per_hi);
    wire light_recent = (gap_q <= per_hi);
    // rx active takes any light, else only in-range carrier
    wire demod_zero = rx_active ? light_recent : car_ok_q;
    wire baseband = demod_en ? !demod_zero : !rx_light_q;

    // edge timing of the selected input
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_light_q <= 1'b0;
            rx_prev_q <= 1'b0;
            gap_q <= 10'h3FF;
            car_ok_q <= 1'b0;
        end
        else
        begin
            rx_light_q <= rx_light;
            rx_prev_q <= rx_light_q;
            gap_q <= rx_rise ? 10'h000 : (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001;
            if (rx_rise)
                car_ok_q <= in_range;
            else if (!light_recent)
                car_ok_q <= 1'b0;
        end
    end

    ////////////////////////////////////////
    // receive engine, idle while transmitting
    char_state_e rx_st_q;
    logic [3:0] rx_cnt_q;
    logic [2:0] rx_idx_q;
    logic [7:0] rx_sh_q;
    logic [2:0] maj_q; // last three baseband samples
    logic ovr_q; // sticky overrun
    wire rx_run = rx_go && (tx_st_q == CH_IDLE);
    wire maj = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) | (maj_q[0] & maj_q[2]);
    wire rx_bit = oversample ? maj : baseband;
    wire rx_samp = samp_tick && (rx_cnt_q == SAMPLE_MID);
    wire rx_done = (rx_st_q == CH_STOP) && rx_samp && rx_bit;

    // start detect, mid-bit sampling, stop check
    always_ff @(posedge core_clk)
    begin
        if (reset || !rx_run)
        begin
            rx_st_q <= CH_IDLE;
            rx_cnt_q <= 4'h0;
            rx_idx_q <= 3'h0;
            rx_sh_q <= 8'h00;
            maj_q <= 3'b111;
        end
        else if (samp_tick)
        begin
            maj_q <= {maj_q[1:0], baseband};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            case (rx_st_q)
                CH_IDLE:
                begin
                    // count the start bit from its falling edge
                    rx_cnt_q <= 4'h1;
                    if (!baseband)
                        rx_st_q <= CH_START;
                end
                CH_START:
                    if (rx_samp && rx_bit)
                        rx_st_q <= CH_IDLE; // glitch, not a start bit
                    else if (rx_cnt_q == SAMPLE_LAST)
                    begin
                        rx_st_q <= CH_DATA;
                        rx_idx_q <= 3'h0;
                    end
                CH_DATA:
                begin
                    if (rx_samp)
                        rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
                    if (rx_cnt_q == SAMPLE_LAST)
                    begin
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == LAST_DATA_BIT)
                            rx_st_q <= CH_STOP;
                    end
                end
                default:
                    // a bad stop bit drops the byte silently
                    if (rx_samp)
                        rx_st_q <= CH_IDLE;
            endcase
        end
    end

    // holding register and overrun; new byte beats read
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
            ovr_q <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                rx_data_q <= rx_sh_q;
                rx_valid_q <= 1'b1;
            end
            else if (rx_read)
                rx_valid_q <= 1'b0;
            if (rx_done && rx_valid_q && !rx_read)
                ovr_q <= 1'b1;
            else if (overrun_clear)
                ovr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////
    // interrupt identification, gating and irq channel
    wire tx_below = ({2'b00, fifo_level} < {2'b00, preamble_level_reg[5:0]});
    wire [7:0] ident_d = (8'(rx_valid_q) << IIR_RX_THR) | (8'(tx_below) << IIR_TX_THR) | (8'(ovr_q) << IIR_RX_OVR) | (8'(unr_q) << IIR_TX_UNR);
    wire irq_d = (ident_d[IIR_RX_THR] && interrupt_enable_reg[IER_RX_THR]) || (ident_d[IIR_TX_THR] && interrupt_enable_reg[IER_TX_THR]) || (ident_d[IIR_RX_OVR] && interrupt_enable_reg[IER_RX_OVR]) || (ident_d[IIR_TX_UNR] && interrupt_enable_reg[IER_TX_UNR]);

    // registered status and pin drive
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            interrupt_ident_reg <= 8'h00;
            irq_q <= 1'b0;
            irq_oe_q <= 1'b0;
        end
        else
        begin
            interrupt_ident_reg <= ident_d;
            irq_q <= irq_d && modem_control_reg[MCR_IRQ_EN];
            irq_oe_q <= modem_control_reg[MCR_IRQ_EN];
        end
    end
endmodule
`default_nettype wire

/* tb/ir_codec_assertions.sv */
// port checks of the ask / tv codec
// assumes a bind to the codec top, one clock
`timescale 1ns/10ps
`default_nettype none
module ir_codec_assertions
    import ir_modes_pkg::*;
(
    input wire logic core_clk, reset, fifo_control_wr, tx_ready_q, rx_valid_q, rx_read, irq_q, irq_oe_q, ir_tx_q,
    input wire logic [7:0] mode_definition_reg, aux_control_reg, line_control_reg, modem_control_reg,
    input wire logic [7:0] interrupt_enable_reg, fifo_control_reg, interrupt_ident_reg
);
    logic [7:0] hi_cnt_q; // emitter high run length
    // count consecutive lit cycles
    always_ff @(posedge core_clk)
        hi_cnt_q <= (reset || !ir_tx_q) ? 8'h00 : hi_cnt_q + 8'h01;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence clear_unlocked_s;
        fifo_control_wr && fifo_control_reg[FCR_CLEAR] && line_control_reg[LCR_UNLOCK];
    endsequence
    irq_float_a: assert property (!modem_control_reg[MCR_IRQ_EN] [*2] |-> !irq_oe_q)
        else $error("irq driven");
    irq_drive_a: assert property (modem_control_reg[MCR_IRQ_EN] [*2] |-> irq_oe_q)
        else $error("irq not driven");
    irq_gate_a: assert property (((interrupt_enable_reg & 8'h2B) == 8'h00) [*2] |-> !irq_q)
        else $error("irq gated off");
    tx_quiet_a: assert property (!aux_control_reg[ACR_TX_EN] [*2] |-> !ir_tx_q)
        else $error("lit while tx off");
    ask_burst_a: assert property (mode_definition_reg[2:0] == MODE_ASK |-> hi_cnt_q <= ASK_CAR_HIGH)
        else $error("carrier too long");
    clear_done_a: assert property (clear_unlocked_s |-> ##[1:2] tx_ready_q)
        else $error("clear ignored");
    clear_lock_a: assert property (!tx_ready_q && !aux_control_reg[ACR_TX_EN] && !line_control_reg[LCR_UNLOCK]
        |=> !tx_ready_q)
        else $error("locked clear");
    rx_hold_a: assert property (rx_valid_q && !rx_read |=> rx_valid_q)
        else $error("rx byte lost");
    rx_flag_a: assert property ($rose(rx_valid_q) |-> ##[0:1] interrupt_ident_reg[IIR_RX_THR])
        else $error("rx flag missing");
endmodule
bind ir_ask_tv_codec ir_codec_assertions ir_codec_assertions_inst (.*);
`default_nettype wire

/* tb/ir_transceiver_model.sv */
// transceiver model: detector pins from a framed byte
// assumes demodulation off: light is a zero bit
`timescale 1ns/10ps
`default_nettype none
module ir_transceiver_model #(
    parameter int BIT_CYC = 32
) (
    // clock
    input wire logic core_clk,
    // byte to send, start pulse, listened pin
    input wire logic [7:0] send_byte,
    input wire logic send_go,
    input wire logic use_low,
    // detector pins
    output logic ir_rx_active_low,
    output logic ir_rx_active_high
);
    logic light; // dark when idle
    wire [9:0] frame_w = {1'b1, send_byte, 1'b0};
    // the other pin shows steady light, spoiling a wrong pick
    assign ir_rx_active_high = use_low | light;
    assign ir_rx_active_low = ~light & use_low;
    initial light = 1'b0;
    // start lit, data lsb first, stop dark
    always @(posedge core_clk)
    begin
        if (send_go)
        begin
            for (int b = 0; b < 10; b++)
            begin
                light <= ~frame_w[b];
                repeat (BIT_CYC) @(posedge core_clk);
            end
        end
    end
endmodule
`default_nettype wire

/* tb/test_ir_ask_tv_codec.sv */
// self-checking bench for the ask / tv infrared codec
// assumes the transceiver model on the infrared side
`timescale 1ns/10ps
`default_nettype none
module test_ir_ask_tv_codec;
    import ir_modes_pkg::*;
    logic core_clk, reset, fifo_control_wr, tx_valid, rx_read, overrun_clear, underrun_clear, send_go, lit;
    logic tx_ready_q, rx_valid_q, irq_q, irq_oe_q, ir_tx_q, ir_rx_active_low, ir_rx_active_high;
    logic [7:0] clock_prescaler, aux_divisor_low, aux_divisor_high, mode_definition_reg, remote_mode_config;
    logic [7:0] tx_carrier_config, rx_demod_config, infrared_config, aux_control_reg, line_control_reg;
    logic [7:0] modem_control_reg, interrupt_enable_reg, preamble_level_reg, fifo_control_reg, tx_data;
    logic [7:0] rx_data_q, interrupt_ident_reg, send_byte;
    logic [31:0] rnd_q;
    int fails, checked, n;
    ir_ask_tv_codec ir_ask_tv_codec_inst (.*);
    ir_transceiver_model #(.BIT_CYC(32)) ir_transceiver_model_inst (.*, .use_low(infrared_config[INFRARED_CONFIG_RX_SEL]));
    // stimulus shift register step
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // line level of bit i of a framed byte
    function automatic logic frame_bit(input logic [7:0] b, input int i);
        return 1'({1'b1, b, 1'b0} >> i);
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one far side frame, then wait it out
    task automatic send(input logic [7:0] b);
        send_byte = b;
        send_go = 1'b1;
        @(negedge core_clk);
        send_go = 1'b0;
        repeat (400) @(negedge core_clk);
    endtask
    task automatic close_out;
        $display("counts: %0d checked, %0d fails", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // watchdog, twice the expected run
    initial
    begin
        repeat (50000) @(posedge core_clk);
        fails++;
        close_out;
    end
    initial
    begin
        {reset, fifo_control_wr, tx_valid, rx_read, overrun_clear, underrun_clear, send_go} = 7'h40;
        {clock_prescaler, aux_divisor_high, aux_divisor_low, aux_control_reg, line_control_reg} = 40'h05_0019_0000;
        {mode_definition_reg, remote_mode_config, infrared_config} = {5'h00, MODE_ASK, 16'h0000};
        {modem_control_reg, interrupt_enable_reg, preamble_level_reg, fifo_control_reg} = 32'h082B_0420;
        rnd_q = 32'h0001_5252;
        {tx_carrier_config, rx_demod_config, tx_data, send_byte} = rnd_q;
        {fails, checked} = 64'h0;
        repeat (6) @(negedge core_clk);
        reset = 1'b0;
        check("reset outputs", 8'h08, {4'h0, tx_ready_q, rx_valid_q, irq_oe_q, ir_tx_q});
        // ask: untagged byte, bit time 5*25*16
        rnd_q = step(rnd_q);
        {aux_control_reg, tx_data, tx_valid} = {8'h80, rnd_q[7:0], 1'b1};
        @(negedge core_clk);
        tx_valid = 1'b0;
        n = 0;
        while (ir_tx_q !== 1'b1 && n < 4000)
        begin
            @(negedge core_clk);
            n++;
        end
        for (int i = 0; i < 10; i++)
        begin
            lit = 1'b0;
            repeat (8) @(negedge core_clk);
            repeat (2000 - 16)
            begin
                @(negedge core_clk);
                lit = lit | ir_tx_q;
            end
            repeat (8) @(negedge core_clk);
            check("light in bit", {7'h00, ~frame_bit(tx_data, i)}, {7'h00, lit});
        end
        repeat (20) @(negedge core_clk);
        check("tx flags", 8'h22, interrupt_ident_reg & 8'h33);
        underrun_clear = 1'b1;
        @(negedge core_clk);
        underrun_clear = 1'b0;
        @(negedge core_clk);
        check("tx flags cleared", 8'h02, interrupt_ident_reg & 8'h33);
        $display("ask transmit test done");
        // rx on each pin: byte, then overrun
        {clock_prescaler, aux_divisor_high, aux_divisor_low, aux_control_reg} = 32'h0100_0240;
        for (int s = 0; s < 2; s++)
        begin
            infrared_config = {6'h00, s[0], 1'b0};
            rnd_q = step(rnd_q);
            send(rnd_q[7:0]);
            check("rx byte", rnd_q[7:0], rx_data_q);
            check("rx flags", 8'h03, interrupt_ident_reg & 8'h13);
            send(rnd_q[15:8]);
            check("rx newer byte", rnd_q[15:8], rx_data_q);
            check("rx overrun", 8'h13, interrupt_ident_reg & 8'h13);
            check("irq raised", 8'h03, {6'h00, irq_q, irq_oe_q});
            {rx_read, overrun_clear} = 2'h3;
            @(negedge core_clk);
            {rx_read, overrun_clear} = 2'h0;
            repeat (2) @(negedge core_clk);
            check("rx drained", 8'h00, {interrupt_ident_reg[4], interrupt_ident_reg[0], 5'h00, rx_valid_q});
        end
        $display("receive test done");
        // fill until refused, clear locked then unlocked
        {aux_control_reg, tx_valid, n} = {8'h00, 1'b1, 32'h0};
        while (tx_ready_q === 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        tx_valid = 1'b0;
        check("fifo depth", 8'h20, n[7:0]);
        for (int k = 0; k < 2; k++)
        begin
            {line_control_reg, fifo_control_wr} = {k[0], 8'h01};
            @(negedge core_clk);
            fifo_control_wr = 1'b0;
            repeat (2) @(negedge core_clk);
            check("after clear", {6'h00, k[0], k[0]}, {6'h00, tx_ready_q, interrupt_ident_reg[1]});
        end
        $display("fifo test done");
        {modem_control_reg, interrupt_enable_reg} = 16'h0000;
        repeat (3) @(negedge core_clk);
        check("irq released", 8'h00, {6'h00, irq_q, irq_oe_q});
        $display("irq test done");
        close_out;
    end
endmodule
`default_nettype wire
